// file: cycle_timing_pkg.sv
// Package of operation codes, cycle figures and carrier types for the cycle timer.
package cycle_timing_pkg;

    // ****************************************************************
    // Operation classes
    // ****************************************************************
    typedef enum logic [3:0] {
        OP_SCAN      = 4'h0,
        OP_STORE     = 4'h1,
        OP_SHL1      = 4'h2,
        OP_SHL_CNT   = 4'h3,
        OP_ROR_CNT   = 4'h4,
        OP_SUB_IMM   = 4'h5,
        OP_SBB_RM    = 4'h6,
        OP_SBB_ACC   = 4'h7,
        OP_TEST_ACC  = 4'h8,
        OP_XOR_ACC   = 4'h9
    } op_class_t;

    // ****************************************************************
    // Cycle figures
    // ****************************************************************
    localparam logic [11:0] SCAN_ONE      = 12'h00F;
    localparam logic [11:0] SCAN_BASE     = 12'h005;
    localparam logic [11:0] SCAN_EACH     = 12'h00F;
    localparam logic [11:0] STORE_ONE     = 12'h00A;
    localparam logic [11:0] STORE_BASE    = 12'h006;
    localparam logic [11:0] STORE_EACH    = 12'h009;
    localparam logic [11:0] SHL1_REG      = 12'h002;
    localparam logic [11:0] SHL1_MEM      = 12'h00F;
    localparam logic [11:0] CNT_REG_BASE  = 12'h005;
    localparam logic [11:0] CNT_MEM_BASE  = 12'h011;
    localparam logic [11:0] SUBI_REG      = 12'h004;
    localparam logic [11:0] SUBI_MEM      = 12'h010;
    localparam logic [11:0] SBB_REG       = 12'h003;
    localparam logic [11:0] SBB_MEM       = 12'h00A;
    localparam logic [11:0] ACC_BYTE      = 12'h003;
    localparam logic [11:0] ACC_WORD      = 12'h004;
    localparam logic [11:0] NARROW_WORD   = 12'h004;
    localparam logic [11:0] ZERO_COUNT    = 12'h000;
    localparam logic [11:0] ONE_COUNT     = 12'h001;

    // ****************************************************************
    // Carrier
    // ****************************************************************
    typedef struct packed {
        op_class_t   op;
        logic        mem;
        logic        word;
        logic        rep;
        logic [7:0]  n;
    } op_req_t;

endpackage // cycle_timing_pkg

// file: cycle_timer.sv
// Execution-time engine that holds busy for each operation's documented cycle count.
`timescale 1ns/1ps
// Function
// - Scan takes 15 cycles, or 5+15n when repeated n times.
// - Store takes 10 cycles, or 6+9n when repeated n times.
// - Shift left by one: 2 cycles register, 15 cycles memory.
// - Shift left by count: 5+n register, 17+n memory.
// - Rotate right by count: 5+n register, 17+n memory.
// - Subtract immediate: 4 cycles register, 16 cycles memory.
// - Subtract with borrow register forms: 3 register, 10 memory.
// - Subtract with borrow immediate from accumulator: 3 byte, 4 word.
// - Test immediate against accumulator: 3 byte, 4 word.
// - Exclusive-or immediate into accumulator: 3 byte, 4 word.
// - Narrow bus adds 4 cycles per word memory transfer.
module cycle_timer (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       sys_rst_i,
    // Bus width strap: high for the 8-bit external bus variant
    input  wire logic                       narrow_bus_i,
    // Operation request
    input  wire logic                       start_i,
    input  wire cycle_timing_pkg::op_req_t  req_i,
    // Status
    output logic                            busy_o,
    output logic                            done_o,
    output logic [11:0]                     total_o
);
    import cycle_timing_pkg::*;

    // ****************************************************************
    // Cycle count decode
    // ****************************************************************
    function automatic logic [11:0] base_cycles(input op_req_t r);
        logic [11:0] n12;
        logic [11:0] c;
        n12 = {4'h0, r.n};
        c   = ZERO_COUNT;
        case (r.op)
            OP_SCAN: begin
                c = r.rep ? 12'(SCAN_BASE + SCAN_EACH * n12) : SCAN_ONE;
            end
            OP_STORE: begin
                c = r.rep ? 12'(STORE_BASE + STORE_EACH * n12) : STORE_ONE;
            end
            OP_SHL1: begin
                c = r.mem ? SHL1_MEM : SHL1_REG;
            end
            OP_SHL_CNT, OP_ROR_CNT: begin
                c = 12'((r.mem ? CNT_MEM_BASE : CNT_REG_BASE) + n12);
            end
            OP_SUB_IMM: begin
                c = r.mem ? SUBI_MEM : SUBI_REG;
            end
            OP_SBB_RM: begin
                c = r.mem ? SBB_MEM : SBB_REG;
            end
            OP_SBB_ACC, OP_TEST_ACC, OP_XOR_ACC: begin
                c = r.word ? ACC_WORD : ACC_BYTE;
            end
            default: begin
                c = ZERO_COUNT;
            end
        endcase
        return c;
    endfunction

    // Memory transfers made by the operation, used for the narrow bus penalty.
    function automatic logic [11:0] mem_transfers(input op_req_t r);
        logic [11:0] t;
        t = ZERO_COUNT;
        case (r.op)
            OP_SCAN, OP_STORE: begin
                t = r.rep ? {4'h0, r.n} : ONE_COUNT;
            end
            OP_SHL1, OP_SHL_CNT, OP_ROR_CNT, OP_SUB_IMM, OP_SBB_RM: begin
                t = r.mem ? ONE_COUNT : ZERO_COUNT;
            end
            default: begin
                t = ZERO_COUNT;
            end
        endcase
        return t;
    endfunction

    // ****************************************************************
    // State machine
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } state_t;

    state_t      state_reg,  state_next;
    logic [11:0] remain_reg, remain_next;
    logic [11:0] total_reg,  total_next;
    logic        done_reg,   done_next;
    logic [11:0] cost;

    always_comb begin
        cost = base_cycles(req_i);
        if (narrow_bus_i && req_i.word) begin
            cost = 12'(cost + NARROW_WORD * mem_transfers(req_i));
        end
    end

    // A request is taken only while idle; one issued while busy is dropped, which
    // keeps the model simple at the price of no queueing of back-to-back requests.
    always_comb begin
        state_next  = state_reg;
        remain_next = remain_reg;
        total_next  = total_reg;
        done_next   = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                // Zero wait start
                // A start in the done cycle is dropped, since busy still stands there.
                if (start_i && !done_reg) begin
                    total_next = cost;
                    if (cost <= ONE_COUNT) begin
                        done_next = 1'b1;
                    end else begin
                        remain_next = 12'(cost - ONE_COUNT);
                        state_next  = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (remain_reg == ONE_COUNT) begin
                    done_next  = 1'b1;
                    state_next = ST_IDLE;
                end
                remain_next = 12'(remain_reg - ONE_COUNT);
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_reg  <= ST_IDLE;
            remain_reg <= ZERO_COUNT;
            total_reg  <= ZERO_COUNT;
            done_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            remain_reg <= remain_next;
            total_reg  <= total_next;
            done_reg   <= done_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    logic busy_reg;
    logic busy_next;

    always_comb begin
        busy_next = (state_next == ST_RUN) || done_next;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= busy_next;
        end
    end

    assign busy_o  = busy_reg;
    assign done_o  = done_reg;
    assign total_o = total_reg;

endmodule // cycle_timer

// file: cycle_timer_chk_assertions.sv
// Checker of the cycle timer's status outputs against operation costs.
`timescale 1ns/1ps
module cycle_timer_chk (
    input wire logic                      clk_i,
    input wire logic                      sys_rst_i,
    input wire logic                      narrow_bus_i,
    input wire logic                      start_i,
    input wire cycle_timing_pkg::op_req_t req_i,
    input wire logic                      busy_o,
    input wire logic                      done_o,
    input wire logic [11:0]               total_o
);
    import cycle_timing_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // A request counts only when idle, since one made while busy is dropped.
    wire tk = start_i && !busy_o;
    wire rg = tk && !req_i.mem;
    wire np = !(narrow_bus_i && req_i.word);
    property p_shl; rg && req_i.op == OP_SHL1 |=> !done_o ##1 done_o ##1 !busy_o; endproperty
    a_shl: assert property (p_shl) else $error("shift one");
    property p_cnt; rg && req_i.op inside {OP_SHL_CNT, OP_ROR_CNT}
        |=> total_o == CNT_REG_BASE + $past(req_i.n); endproperty
    a_cnt: assert property (p_cnt) else $error("count form");
    property p_sub; rg && req_i.op == OP_SUB_IMM |=> busy_o ##3 done_o; endproperty
    a_sub: assert property (p_sub) else $error("sub imm");
    property p_sbb; rg && req_i.op == OP_SBB_RM |=> total_o == SBB_REG; endproperty
    a_sbb: assert property (p_sbb) else $error("sbb reg");
    property p_acc; tk && req_i.op inside {OP_SBB_ACC, OP_TEST_ACC, OP_XOR_ACC}
        |=> total_o == ($past(req_i.word) ? ACC_WORD : ACC_BYTE); endproperty
    a_acc: assert property (p_acc) else $error("acc form");
    property p_pen; tk && !np && req_i.mem && req_i.op == OP_SBB_RM
        |=> total_o == SBB_MEM + NARROW_WORD; endproperty
    a_pen: assert property (p_pen) else $error("word penalty");
    property p_scn; tk && np && req_i.op == OP_SCAN && !req_i.rep |=> total_o == SCAN_ONE; endproperty
    a_scn: assert property (p_scn) else $error("scan");
    property p_sto; tk && np && req_i.op == OP_STORE && req_i.rep
        |=> total_o == STORE_BASE + STORE_EACH * $past(req_i.n); endproperty
    a_sto: assert property (p_sto) else $error("store rep");
endmodule // cycle_timer_chk
bind cycle_timer cycle_timer_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .narrow_bus_i(narrow_bus_i), .start_i(start_i), .req_i(req_i), .busy_o(busy_o),
    .done_o(done_o), .total_o(total_o));

// file: ext_mem_model.sv
// Model of the external memory side: bus width strap, zero wait states.
`timescale 1ns/1ps
module ext_mem_model (
    input  wire logic sel_narrow_i,
    output logic      narrow_bus_o
);
    assign narrow_bus_o = sel_narrow_i;
endmodule // ext_mem_model

// file: testbench.sv
// Self-checking bench of the cycle timer.
`timescale 1ns/1ps
module testbench;
    import cycle_timing_pkg::*;
    // Row: op, flags {mem, word, rep, narrow}, count, pad, expected cycles.
    localparam logic [31:0] ROWS [27] = '{
        32'h0000_000F, 32'h0203_0032, 32'h1000_000A, 32'h1204_002A, 32'h2000_0002, 32'h2800_000F,
        32'h3007_000C, 32'h38FF_0110, 32'h4000_0005, 32'h4803_0014, 32'h5000_0004, 32'h5800_0010,
        32'h6000_0003, 32'h6800_000A, 32'h7000_0003, 32'h7400_0004, 32'h8000_0003, 32'h8400_0004,
        32'h9000_0003, 32'h9400_0004, 32'h0702_002B, 32'h1500_000E, 32'h6D00_000E, 32'h9500_0004,
        32'h2900_000F, 32'h6C00_000A, 32'h1700_0006};
    logic        clk_i, sys_rst_i, start_i, sel_narrow, narrow_bus_i, busy_o, done_o;
    op_req_t     req_i;
    logic [11:0] total_o, len, dn;
    int          fails = 0, n_checks = 0, cyc = 0, poke = 0;
    ext_mem_model u_mem (.sel_narrow_i(sel_narrow), .narrow_bus_o(narrow_bus_i));
    cycle_timer DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .narrow_bus_i(narrow_bus_i),
        .start_i(start_i), .req_i(req_i), .busy_o(busy_o), .done_o(done_o), .total_o(total_o));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) fails++;
        if (cyc == 3000) wrap_up();
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) fails++;
        if (got !== exp) $display("[ERR] %0t got %0d want %0d", $time, got, exp);
    endtask
    // Busy cycles and done pulses are counted; a second start may be poked in.
    task automatic run(input logic [31:0] row);
        req_i = op_req_t'({row[31:25], row[23:16]});
        sel_narrow = row[24];
        start_i = 1'b1;
        @(posedge clk_i);
        #1;
        len = 12'h000;
        dn = 12'h000;
        while (busy_o === 1'b1 && len < 12'h3FF) begin
            len++;
            dn = dn + {11'h000, done_o};
            start_i = (len == poke);
            @(posedge clk_i);
            #1;
        end
        start_i = 1'b0;
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        sys_rst_i = 1'b1;
        start_i = 1'b0;
        sel_narrow = 1'b0;
        req_i = '0;
        repeat (16) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        chk({done_o, busy_o, total_o[9:0]}, 12'h000);
        chk(total_o, 12'h000);
        foreach (ROWS[i]) begin
            run(ROWS[i]);
            chk(len, ROWS[i][11:0]);
            chk(total_o, ROWS[i][11:0]);
            chk(dn, 12'h001);
        end
        // Starts in mid-operation and in the done cycle must be dropped.
        poke = 2;
        run(ROWS[1]);
        chk(len, 12'h032);
        poke = 4;
        run(ROWS[10]);
        chk(len, 12'h004);
        wrap_up();
    end
endmodule // testbench
